//--- rtl/gpio_expander.sv
// Top: two-wire bus slave with four registers driving a four-line port.
// Assumes scl and sda are asynchronous pins; sda is open drain, sda_oe pulls low.
`timescale 1ns/100ps
// Notes on behaviour
// - Input register shows pin levels always
// - Writes to input register are ignored
// - Output bits drive only output pins
// - Output register reads stored value
// - Invert bit flips reported input level
// - Direction one means input, zero output
// - Reset: idle, output ones, invert zeros, direction ones
// - Any number of written data bytes
// - Restart keeps currently selected register
// - Read data captured at acknowledge rise
// - Unlimited read bytes, release after nack
// - Stop returns device to idle
// - Answer address 0x41 only, acknowledge low
// - Low command bits select one register
// - Command persists until rewritten
// - Acknowledge address and each written byte during clock high
module gpio_expander (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic [3:0] port_in,
   output logic [3:0] port_out,
   output logic [3:0] port_oe
);
   gpio_port_if port ();
   logic [1:0] scl_s_r;
   logic [1:0] sda_s_r;
   logic scl_d_r;
   logic sda_d_r;
   gpio_expander_pkg::link_state_t state_r;
   logic [3:0] bit_cnt_r;
   logic [7:0] shift_r;
   logic [7:0] tx_r;
   logic [7:0] cmd_r;
   logic cmd_phase_r;
   logic drive_low_r;
   logic [7:0] out_r;
   logic [7:0] inv_r;
   logic [7:0] dir_r;

   wire scl_now = scl_s_r[1];
   wire sda_now = sda_s_r[1];
   wire scl_rise = scl_now & ~scl_d_r;
   wire scl_fall = ~scl_now & scl_d_r;
   wire start_seen = scl_now & scl_d_r & sda_d_r & ~sda_now;
   wire stop_seen = scl_now & scl_d_r & ~sda_d_r & sda_now;
   wire [7:0] rx_byte = {shift_r[6:0], sda_now};
   wire addr_match = (shift_r[7:1] == gpio_expander_pkg::SLAVE_ADDR);
   wire is_read = shift_r[0];
   wire [1:0] sel = cmd_r[1:0];

   function automatic logic [7:0] reg_view(input logic [1:0] s, input logic [7:0] inp,
                                          input logic [7:0] o, input logic [7:0] n,
                                          input logic [7:0] c);
      case (s)
         gpio_expander_pkg::SEL_INPUT: reg_view = inp;
         gpio_expander_pkg::SEL_OUTPUT: reg_view = o;
         gpio_expander_pkg::SEL_INVERT: reg_view = n;
         default: reg_view = c;
      endcase
   endfunction

   wire [7:0] read_val = reg_view(sel, port.input_view, out_r, inv_r, dir_r);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         scl_s_r <= 2'h3;
         sda_s_r <= 2'h3;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_s_r <= {scl_s_r[0], scl};
         sda_s_r <= {sda_s_r[0], sda_in};
         scl_d_r <= scl_now;
         sda_d_r <= sda_now;
      end
   end

   // Serial engine: bits counted on scl rise, sda changes on scl fall
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= gpio_expander_pkg::ST_IDLE;
         bit_cnt_r <= 4'h0;
         shift_r <= 8'h00;
         tx_r <= 8'h00;
         cmd_r <= gpio_expander_pkg::CMD_RST;
         cmd_phase_r <= 1'b0;
         drive_low_r <= 1'b0;
      end else if (start_seen) begin
         state_r <= gpio_expander_pkg::ST_ADDR;
         bit_cnt_r <= 4'h0;
         drive_low_r <= 1'b0;
      end else if (stop_seen) begin
         state_r <= gpio_expander_pkg::ST_IDLE;
         drive_low_r <= 1'b0;
      end else begin
         case (state_r)
            gpio_expander_pkg::ST_IDLE: begin
               drive_low_r <= 1'b0;
            end
            gpio_expander_pkg::ST_ADDR: begin
               if (scl_rise) begin
                  shift_r <= rx_byte;
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (scl_fall && bit_cnt_r == gpio_expander_pkg::BIT_ACK) begin
                  bit_cnt_r <= 4'h0;
                  if (addr_match) begin
                     drive_low_r <= 1'b1;
                     state_r <= gpio_expander_pkg::ST_ADDR_ACK;
                  end else begin
                     state_r <= gpio_expander_pkg::ST_IDLE;
                  end
               end
            end
            gpio_expander_pkg::ST_ADDR_ACK: begin
               if (scl_rise) begin
                  tx_r <= read_val;
               end else if (scl_fall) begin
                  if (is_read) begin
                     state_r <= gpio_expander_pkg::ST_RD;
                     drive_low_r <= ~tx_r[7];
                  end else begin
                     state_r <= gpio_expander_pkg::ST_WR;
                     cmd_phase_r <= 1'b1;
                     drive_low_r <= 1'b0;
                  end
               end
            end
            gpio_expander_pkg::ST_WR: begin
               if (scl_rise) begin
                  shift_r <= rx_byte;
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (scl_fall && bit_cnt_r == gpio_expander_pkg::BIT_ACK) begin
                  bit_cnt_r <= 4'h0;
                  drive_low_r <= 1'b1;
                  state_r <= gpio_expander_pkg::ST_WR_ACK;
                  if (cmd_phase_r) begin
                     cmd_r <= shift_r;
                  end
               end
            end
            gpio_expander_pkg::ST_WR_ACK: begin
               if (scl_fall) begin
                  drive_low_r <= 1'b0;
                  cmd_phase_r <= 1'b0;
                  state_r <= gpio_expander_pkg::ST_WR;
               end
            end
            gpio_expander_pkg::ST_RD: begin
               if (scl_rise) begin
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt_r == gpio_expander_pkg::BIT_ACK) begin
                     bit_cnt_r <= 4'h0;
                     drive_low_r <= 1'b0;
                     state_r <= gpio_expander_pkg::ST_RD_ACK;
                  end else begin
                     drive_low_r <= ~tx_r[3'(gpio_expander_pkg::BIT_LAST - bit_cnt_r)];
                  end
               end
            end
            gpio_expander_pkg::ST_RD_ACK: begin
               if (scl_rise) begin
                  tx_r <= read_val;
                  if (sda_now) begin
                     state_r <= gpio_expander_pkg::ST_IDLE;
                  end
               end else if (scl_fall) begin
                  state_r <= gpio_expander_pkg::ST_RD;
                  drive_low_r <= ~tx_r[7];
               end
            end
            default: state_r <= gpio_expander_pkg::ST_IDLE;
         endcase
      end
   end

   // Register writes land on the data byte ack; input register is not writable
   wire data_done = (state_r == gpio_expander_pkg::ST_WR) && scl_fall && !start_seen &&
                    !stop_seen && (bit_cnt_r == gpio_expander_pkg::BIT_ACK) && !cmd_phase_r;
   wire wr_out = data_done && (sel == gpio_expander_pkg::SEL_OUTPUT);
   wire wr_inv = data_done && (sel == gpio_expander_pkg::SEL_INVERT);
   wire wr_dir = data_done && (sel == gpio_expander_pkg::SEL_DIR);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         out_r <= gpio_expander_pkg::OUTPUT_RST;
         inv_r <= gpio_expander_pkg::INVERT_RST;
         dir_r <= gpio_expander_pkg::DIR_RST;
      end else begin
         if (wr_out) out_r <= {gpio_expander_pkg::OUTPUT_RST[7:4], shift_r[3:0]};
         if (wr_inv) inv_r <= {gpio_expander_pkg::INVERT_RST[7:4], shift_r[3:0]};
         if (wr_dir) dir_r <= {gpio_expander_pkg::DIR_RST[7:4], shift_r[3:0]};
      end
   end

   assign port.out_level = out_r;
   assign port.invert_sel = inv_r;
   assign port.dir_sel = dir_r;
   assign sda_out = 1'b0;
   assign sda_oe = drive_low_r;

   gpio_pin_stage pins (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .port(port),
      .pin_in(port_in),
      .pin_out(port_out),
      .pin_oe(port_oe)
   );

   // Protocol checks on the serial engine, then register and port checks
   a_stop_to_idle: assert property (@(posedge sys_clk) disable iff (!nrst)
      stop_seen |=> (state_r == gpio_expander_pkg::ST_IDLE && !sda_oe))
      else $error("stop did not idle");
   a_ack_on_match: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_r == gpio_expander_pkg::ST_ADDR && scl_fall && !start_seen && !stop_seen &&
       bit_cnt_r == gpio_expander_pkg::BIT_ACK && shift_r[7:1] == gpio_expander_pkg::SLAVE_ADDR)
      |=> sda_oe) else $error("address not acked");
   a_no_ack_mismatch: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_r == gpio_expander_pkg::ST_ADDR && scl_fall && !start_seen && !stop_seen &&
       bit_cnt_r == gpio_expander_pkg::BIT_ACK && shift_r[7:1] != gpio_expander_pkg::SLAVE_ADDR)
      |=> (state_r == gpio_expander_pkg::ST_IDLE && !sda_oe))
      else $error("foreign address acked");
   a_addr_ack_held: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_r == gpio_expander_pkg::ST_ADDR_ACK && scl_now) |-> sda_oe)
      else $error("address ack released in clock high");
   a_wr_ack_held: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_r == gpio_expander_pkg::ST_WR_ACK && scl_now) |-> sda_oe)
      else $error("ack released in clock high");
   a_wr_ack_enter: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_r == gpio_expander_pkg::ST_WR && scl_fall && !start_seen && !stop_seen &&
       bit_cnt_r == gpio_expander_pkg::BIT_ACK)
      |=> (state_r == gpio_expander_pkg::ST_WR_ACK && sda_oe)) else $error("byte not acked");
   a_rx_released: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_r == gpio_expander_pkg::ST_IDLE || state_r == gpio_expander_pkg::ST_ADDR ||
       state_r == gpio_expander_pkg::ST_WR) |-> !sda_oe)
      else $error("data line held while receiving");
   a_out_write: assert property (@(posedge sys_clk) disable iff (!nrst)
      wr_out |=> (out_r[3:0] == $past(shift_r[3:0]) &&
      out_r[7:4] == gpio_expander_pkg::OUTPUT_RST[7:4])) else $error("output write lost");
   a_inv_write: assert property (@(posedge sys_clk) disable iff (!nrst)
      wr_inv |=> (inv_r[3:0] == $past(shift_r[3:0]) &&
      inv_r[7:4] == gpio_expander_pkg::INVERT_RST[7:4])) else $error("invert write lost");
   a_dir_write: assert property (@(posedge sys_clk) disable iff (!nrst)
      wr_dir |=> (dir_r[3:0] == $past(shift_r[3:0]) &&
      dir_r[7:4] == gpio_expander_pkg::DIR_RST[7:4])) else $error("direction write lost");
   a_input_ro: assert property (@(posedge sys_clk) disable iff (!nrst)
      (data_done && sel == gpio_expander_pkg::SEL_INPUT) |=> $stable(out_r) && $stable(inv_r)
      && $stable(dir_r)) else $error("input write changed a register");
   a_cmd_kept: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_r != gpio_expander_pkg::ST_WR) |=> $stable(cmd_r))
      else $error("command changed outside write");
   a_cmd_load: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_r == gpio_expander_pkg::ST_WR && scl_fall && !start_seen && !stop_seen &&
       bit_cnt_r == gpio_expander_pkg::BIT_ACK && cmd_phase_r) |=> (cmd_r == $past(shift_r)))
      else $error("command byte not stored");
   a_restart_keeps: assert property (@(posedge sys_clk) disable iff (!nrst)
      start_seen |=> (state_r == gpio_expander_pkg::ST_ADDR && $stable(cmd_r)))
      else $error("restart lost the command");
   a_rd_first_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_r == gpio_expander_pkg::ST_ADDR_ACK && scl_fall && is_read && !start_seen &&
       !stop_seen) |=> (state_r == gpio_expander_pkg::ST_RD && sda_oe == !tx_r[7]))
      else $error("first read bit wrong");
   a_rd_release: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_r == gpio_expander_pkg::ST_RD && scl_fall && !start_seen && !stop_seen &&
       bit_cnt_r == gpio_expander_pkg::BIT_ACK)
      |=> (state_r == gpio_expander_pkg::ST_RD_ACK && !sda_oe)) else $error("byte end held");
   a_master_ack_free: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_r == gpio_expander_pkg::ST_RD_ACK) |-> !sda_oe)
      else $error("data line held in master ack");
   a_rd_load: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_r == gpio_expander_pkg::ST_RD_ACK && scl_rise && !start_seen && !stop_seen)
      |=> (tx_r == $past(read_val))) else $error("read data not loaded");
   a_nack_release: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_r == gpio_expander_pkg::ST_RD_ACK && scl_rise && sda_now && !start_seen &&
       !stop_seen) |=> (state_r == gpio_expander_pkg::ST_IDLE) [*2])
      else $error("no release after nack");
   a_upper_defaults: assert property (@(posedge sys_clk) disable iff (!nrst)
      (out_r[7:4] == gpio_expander_pkg::OUTPUT_RST[7:4] &&
       inv_r[7:4] == gpio_expander_pkg::INVERT_RST[7:4] &&
       dir_r[7:4] == gpio_expander_pkg::DIR_RST[7:4])) else $error("unused bits not default");
   a_pins_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
      (port_out == out_r[3:0])) else $error("port level not from output register");
   a_reset_defaults: assert property (@(posedge sys_clk)
      !nrst |=> (out_r == gpio_expander_pkg::OUTPUT_RST && inv_r == gpio_expander_pkg::INVERT_RST
      && dir_r == gpio_expander_pkg::DIR_RST)) else $error("bad reset defaults");
   // Scenario coverage
   c_write_data: cover property (@(posedge sys_clk) disable iff (!nrst) wr_out);
   c_read_byte: cover property (@(posedge sys_clk) disable iff (!nrst)
      state_r == gpio_expander_pkg::ST_RD_ACK);
   c_restart: cover property (@(posedge sys_clk) disable iff (!nrst)
      start_seen && state_r != gpio_expander_pkg::ST_IDLE);
   c_dir_write: cover property (@(posedge sys_clk) disable iff (!nrst) wr_dir);
   c_read_nack: cover property (@(posedge sys_clk) disable iff (!nrst)
      state_r == gpio_expander_pkg::ST_RD_ACK && scl_rise && sda_now);
endmodule // gpio_expander

//--- rtl/gpio_expander_pkg.sv
// Package: register map, defaults, bus address and state types for the expander.
// Assumes a single 100 MHz system clock; serial bus pins are sampled, not clocks.
package gpio_expander_pkg;
   localparam int PORT_W = 4;
   localparam int REG_W = 8;
   localparam logic [6:0] SLAVE_ADDR = 7'h41;
   localparam logic [1:0] SEL_INPUT = 2'h0;
   localparam logic [1:0] SEL_OUTPUT = 2'h1;
   localparam logic [1:0] SEL_INVERT = 2'h2;
   localparam logic [1:0] SEL_DIR = 2'h3;
   localparam logic [7:0] OUTPUT_RST = 8'hFF;
   localparam logic [7:0] INVERT_RST = 8'h00;
   localparam logic [7:0] DIR_RST = 8'hFF;
   localparam logic [7:0] CMD_RST = 8'h00;
   localparam logic [3:0] UNUSED_IN_HI = 4'hF;
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
   } link_state_t;
endpackage

//--- rtl/gpio_port_if.sv
// Interface: register contents carried from the serial engine to the pin stage.
// Assumes both ends run on sys_clk.
`timescale 1ns/100ps
interface gpio_port_if;
   logic [7:0] out_level;
   logic [7:0] invert_sel;
   logic [7:0] dir_sel;
   logic [7:0] input_view;
   modport regs (output out_level, output invert_sel, output dir_sel, input input_view);
   modport pins (input out_level, input invert_sel, input dir_sel, output input_view);
endinterface

//--- rtl/gpio_pin_stage.sv
// Pin stage: drives and samples the four port lines from the register contents.
// Assumes port inputs come from pins and need two-flop synchronisation.
`timescale 1ns/100ps
module gpio_pin_stage (
   input wire logic sys_clk,
   input wire logic nrst,
   gpio_port_if.pins port,
   input wire logic [3:0] pin_in,
   output logic [3:0] pin_out,
   output logic [3:0] pin_oe
);
   logic [3:0] sync1_r;
   logic [3:0] sync2_r;
   logic [3:0] view_r;
   wire [3:0] view_nxt = sync2_r ^ port.invert_sel[3:0];
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
         view_r <= 4'h0;
      end else begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
         view_r <= view_nxt;
      end
   end
   assign port.input_view = {gpio_expander_pkg::UNUSED_IN_HI, view_r};
   assign pin_out = port.out_level[3:0];
   assign pin_oe = ~port.dir_sel[3:0];
   a_dir_gates_oe: assert property (@(posedge sys_clk) disable iff (!nrst)
      (pin_oe == ~port.dir_sel[3:0])) else $error("pin enable not from direction");
   a_invert_view: assert property (@(posedge sys_clk) disable iff (!nrst)
      (view_r == ($past(sync2_r) ^ $past(port.invert_sel[3:0]))))
      else $error("input view wrong polarity");
endmodule // gpio_pin_stage

//--- dv/bus_master_model.sv
// Behavioural two-wire bus master used as the far side of the expander.
// Assumes the bench resolves the open-drain data wire; clock line idles high.
`timescale 1ns/100ps
module bus_master_model (
   input wire logic sys_clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_pull
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // One bit: data set mid low phase, sampled late in high phase
   task automatic bit_x(input logic b, output logic r);
      repeat (2) @(negedge sys_clk);
      sda_pull = ~b;
      repeat (2) @(negedge sys_clk);
      scl = 1'b1;
      repeat (3) @(negedge sys_clk);
      r = sda_line;
      @(negedge sys_clk);
      scl = 1'b0;
   endtask

   task automatic start_cond();
      repeat (2) @(negedge sys_clk);
      sda_pull = 1'b0;
      repeat (2) @(negedge sys_clk);
      scl = 1'b1;
      repeat (8) @(negedge sys_clk);
      sda_pull = 1'b1;
      repeat (8) @(negedge sys_clk);
      scl = 1'b0;
   endtask

   // Clock then stands still high until the next frame
   task automatic stop_cond();
      repeat (2) @(negedge sys_clk);
      sda_pull = 1'b1;
      repeat (2) @(negedge sys_clk);
      scl = 1'b1;
      repeat (8) @(negedge sys_clk);
      sda_pull = 1'b0;
      repeat (8) @(negedge sys_clk);
   endtask

   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(b[i], r);
      bit_x(1'b1, r);
      ack = ~r;
   endtask

   task automatic get_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
      bit_x(last, r);
   endtask
endmodule // bus_master_model

//--- dv/tb_top.sv
// Self-checking bench: random register traffic over the serial bus, port checks.
// Assumes the master model above; port pins resolved here from enables.
`timescale 1ns/100ps
module tb_top;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [3:0] ext_lvl = 4'h0;
   logic scl;
   logic sda_pull;
   logic sda_oe;
   logic sda_out;
   logic sda_line;
   logic [3:0] port_in;
   logic [3:0] port_out;
   logic [3:0] port_oe;
   logic [7:0] exp_out = gpio_expander_pkg::OUTPUT_RST;
   logic [7:0] exp_inv = gpio_expander_pkg::INVERT_RST;
   logic [7:0] exp_dir = gpio_expander_pkg::DIR_RST;
   logic [1:0] cur_sel = 2'h0;
   int fail_count = 0;
   int n_tests = 0;
   int seed = 57612;

   always #5 sys_clk = ~sys_clk;
   // Open-drain wire with pull-up: device drives its sda_out only when enabled
   assign sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_pull;
   assign port_in = (port_oe & port_out) | (~port_oe & ext_lvl);

   gpio_expander gpio_expander_i (.sys_clk(sys_clk), .nrst(nrst), .scl(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .port_in(port_in),
      .port_out(port_out), .port_oe(port_oe));
   bus_master_model bus_master_model_i (.sys_clk(sys_clk), .sda_line(sda_line),
      .scl(scl), .sda_pull(sda_pull));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   function automatic logic [7:0] exp_reg(input logic [1:0] sel);
      logic [3:0] lvl;
      lvl = (~exp_dir[3:0] & exp_out[3:0]) | (exp_dir[3:0] & ext_lvl);
      case (sel)
         gpio_expander_pkg::SEL_INPUT: return {gpio_expander_pkg::UNUSED_IN_HI, lvl ^ exp_inv[3:0]};
         gpio_expander_pkg::SEL_OUTPUT: return exp_out;
         gpio_expander_pkg::SEL_INVERT: return exp_inv;
         default: return exp_dir;
      endcase
   endfunction

   function automatic void apply(input logic [1:0] sel, input logic [7:0] b);
      case (sel)
         gpio_expander_pkg::SEL_OUTPUT: exp_out = {gpio_expander_pkg::OUTPUT_RST[7:4], b[3:0]};
         gpio_expander_pkg::SEL_INVERT: exp_inv = {gpio_expander_pkg::INVERT_RST[7:4], b[3:0]};
         gpio_expander_pkg::SEL_DIR: exp_dir = {gpio_expander_pkg::DIR_RST[7:4], b[3:0]};
         default: ;
      endcase
   endfunction

   task automatic send(input logic [7:0] b, input logic ack_exp);
      logic ack;
      bus_master_model_i.put_byte(b, ack);
      check({7'h00, ack}, {7'h00, ack_exp});
   endtask

   task automatic addr_cmd(input logic [7:0] cmd);
      bus_master_model_i.start_cond();
      send({gpio_expander_pkg::SLAVE_ADDR, 1'b0}, 1'b1);
      send(cmd, 1'b1);
      cur_sel = cmd[1:0];
   endtask

   task automatic wr(input logic [7:0] cmd, input logic [7:0] d, input int nb);
      logic [7:0] b;
      addr_cmd(cmd);
      for (int i = 0; i < nb; i++) begin
         b = d + 8'(i);
         send(b, 1'b1);
         apply(cmd[1:0], b);
      end
      bus_master_model_i.stop_cond();
      check({port_oe, port_out}, {~exp_dir[3:0], exp_out[3:0]});
   endtask

   task automatic rd(input logic [7:0] cmd, input logic use_cmd, input int nb);
      logic [7:0] d;
      if (use_cmd) addr_cmd(cmd);
      bus_master_model_i.start_cond();
      send({gpio_expander_pkg::SLAVE_ADDR, 1'b1}, 1'b1);
      for (int i = 0; i < nb; i++) begin
         bus_master_model_i.get_byte(i == nb - 1, d);
         check(d, exp_reg(cur_sel));
      end
      bus_master_model_i.stop_cond();
      check({7'h00, sda_oe}, 8'h00);
   endtask

   initial begin
      #500_000;
      fail_count++;
      $display("Error at %0t: watchdog expired", $time);
      give_verdict();
   end

   initial begin
      logic [7:0] c8;
      logic [7:0] d8;
      logic r;
      int nb;
      repeat (10) @(negedge sys_clk);
      nrst = 1'b1;
      repeat (3) @(negedge sys_clk);
      check({port_oe, port_out}, {4'h0, gpio_expander_pkg::OUTPUT_RST[3:0]});
      for (int s = 1; s < 4; s++) rd(8'(s), 1'b1, 1);
      $display("test reset defaults done");
      bus_master_model_i.start_cond();
      send({7'h42, 1'b0}, 1'b0);
      bus_master_model_i.stop_cond();
      rd(8'h03, 1'b1, 1);
      $display("test foreign address done");
      for (int k = 0; k < 24; k++) begin
         c8 = 8'($random(seed));
         d8 = 8'($random(seed));
         nb = 1 + int'($unsigned($random(seed)) % 3);
         ext_lvl = 4'($random(seed));
         wr(c8, d8, nb);
         rd({c8[7:2] ^ 6'h15, c8[1:0]}, 1'b1, nb + 1);
      end
      $display("test random traffic done");
      nrst = 1'b0;
      repeat (4) @(negedge sys_clk);
      nrst = 1'b1;
      exp_out = gpio_expander_pkg::OUTPUT_RST;
      exp_inv = gpio_expander_pkg::INVERT_RST;
      exp_dir = gpio_expander_pkg::DIR_RST;
      cur_sel = gpio_expander_pkg::SEL_INPUT;
      repeat (3) @(negedge sys_clk);
      check({port_oe, port_out}, {4'h0, gpio_expander_pkg::OUTPUT_RST[3:0]});
      for (int s = 0; s < 4; s++) rd(8'(s), s != 0, 1);
      $display("test mid-run reset done");
      wr(8'hFC, 8'h5A, 1);
      ext_lvl = 4'hA;
      rd(8'h00, 1'b0, 2);
      ext_lvl = 4'h5;
      rd(8'h00, 1'b0, 1);
      $display("test read without command done");
      addr_cmd(8'h01);
      for (int i = 0; i < 4; i++) bus_master_model_i.bit_x(1'b0, r);
      bus_master_model_i.stop_cond();
      rd(8'h01, 1'b0, 1);
      $display("test stop mid byte done");
      give_verdict();
   end
endmodule // tb_top
